// ==== bus_error_capture_log.sv ====
// Error capture log registers for the PCI and hub sides of the bridge.
// Assumes the status flags come from the status register outside and
// that configuration reads arrive as a one-cycle strobe with offset.
`timescale 1ns/100ps

module bus_error_capture_log (
    input wire logic clk_in, // Core clock, 125 MHz
    input wire logic reset_n_in, // Sync reset, active low
    // Status flags from the error status register
    input wire logic [11:0] error_status_in, // Flag vector
    // PCI error event and cycle details
    input wire logic pci_error_in, // PCI error event pulse
    input wire logic [3:0] pci_cmd_in, // Bus command
    input wire logic [7:0] pci_be_in, // Byte enables
    input wire logic pci_mode32_in, // Cycle in 32-bit mode
    input wire logic [63:0] pci_addr_in, // Cycle address
    input wire logic pci_dual_addr_in, // Dual address cycle
    input wire logic pci_addr_perr_in, // Address parity error
    input wire logic pci_attr_perr_in, // Attribute parity error
    input wire logic [31:0] pci_attr_in, // Attribute phase value
    input wire logic [63:0] pci_data_in, // Cycle data
    // Hub error event and packet details
    input wire logic hub_error_in, // Hub error event pulse
    input wire logic hub_ib_soft_in, // Event is inbound soft error
    input wire logic [31:0] hub_header_in, // Packet header word
    input wire logic [63:0] hub_addr_in, // Packet address
    input wire logic hub_read_cpl_in, // Packet is read completion
    input wire logic [63:0] hub_dest_addr_in, // Inferred destination
    // Configuration read port
    input wire logic cfg_rd_in, // Read strobe
    input wire logic [4:0] cfg_dev_in, // Device number addressed
    input wire logic [7:0] cfg_offset_in, // Byte offset
    output logic [31:0] cfg_rdata_out, // Read data
    output logic cfg_hit_out, // Offset belongs to this block
    output logic pci_log_valid_out, // PCI logs qualified
    output logic hub_hdr_valid_out, // Hub header qualified
    output logic hub_addr_valid_out // Hub address logs qualified
);

    // =========================================================
    // Log ownership
    logic pci_held_r;
    logic hub_hdr_held_r;
    logic hub_addr_held_r;
    logic pci_load;
    logic hub_hdr_load;
    logic hub_addr_load;
    logic pci_qual;
    logic hub_hdr_qual;
    logic hub_addr_qual;
    logic [15:0] pci_header;
    logic [31:0] pci_addr_lo;
    logic [31:0] pci_addr_hi;
    logic [31:0] pci_data_lo;
    logic [31:0] pci_data_hi;
    logic [31:0] hub_header;
    logic [31:0] hub_addr_lo;
    logic [31:0] hub_addr_hi;
    logic [31:0] rdata_nxt;
    logic hit_nxt;

    function automatic logic any_flag(input logic [11:0] flags,
                                      input logic [11:0] mask);
        any_flag = |(flags & mask);
    endfunction

    assign pci_qual = any_flag(error_status_in,
                               error_log_pkg::PCI_LOG_MASK);
    assign hub_hdr_qual = any_flag(error_status_in,
                                   error_log_pkg::HUB_HDR_MASK);
    assign hub_addr_qual = any_flag(error_status_in,
                                    error_log_pkg::HUB_ADDR_MASK);

    // First error wins; later events are ignored until software clears the flags
    assign pci_load = pci_error_in && !pci_held_r;
    assign hub_hdr_load = hub_error_in && !hub_hdr_held_r;
    assign hub_addr_load = hub_error_in && !hub_ib_soft_in &&
                           !hub_addr_held_r;

    // =========================================================
    // Hold tracking: held from capture until the qualifying flags clear
    always_ff @(posedge clk_in) begin
        if (!reset_n_in) begin
            pci_held_r <= 1'b0;
        end else if (pci_load) begin
            pci_held_r <= 1'b1;
        end else if (!pci_qual) begin
            pci_held_r <= 1'b0;
        end
    end

    always_ff @(posedge clk_in) begin
        if (!reset_n_in) begin
            hub_hdr_held_r <= 1'b0;
        end else if (hub_hdr_load) begin
            hub_hdr_held_r <= 1'b1;
        end else if (!hub_hdr_qual) begin
            hub_hdr_held_r <= 1'b0;
        end
    end

    always_ff @(posedge clk_in) begin
        if (!reset_n_in) begin
            hub_addr_held_r <= 1'b0;
        end else if (hub_addr_load) begin
            hub_addr_held_r <= 1'b1;
        end else if (!hub_addr_qual) begin
            hub_addr_held_r <= 1'b0;
        end
    end

    // =========================================================
    // Capture units
    pci_capture u_pci (
        .clk_in(clk_in),
        .reset_n_in(reset_n_in),
        .load_in(pci_load),
        .cmd_in(pci_cmd_in),
        .be_in(pci_be_in),
        .mode32_in(pci_mode32_in),
        .addr_in(pci_addr_in),
        .dual_addr_in(pci_dual_addr_in),
        .addr_perr_in(pci_addr_perr_in),
        .attr_perr_in(pci_attr_perr_in),
        .attr_in(pci_attr_in),
        .data_in(pci_data_in),
        .header_out(pci_header),
        .addr_lo_out(pci_addr_lo),
        .addr_hi_out(pci_addr_hi),
        .data_lo_out(pci_data_lo),
        .data_hi_out(pci_data_hi)
    );

    hub_capture u_hub (
        .clk_in(clk_in),
        .reset_n_in(reset_n_in),
        .hdr_load_in(hub_hdr_load),
        .addr_load_in(hub_addr_load),
        .hdr_in(hub_header_in),
        .addr_in(hub_addr_in),
        .read_cpl_in(hub_read_cpl_in),
        .dest_addr_in(hub_dest_addr_in),
        .header_out(hub_header),
        .addr_lo_out(hub_addr_lo),
        .addr_hi_out(hub_addr_hi)
    );

    // =========================================================
    // Configuration read decode; writes have no port, logs are read-only
    always_comb begin
        rdata_nxt = 32'h0000_0000;
        hit_nxt = 1'b1;
        unique case (cfg_offset_in)
            error_log_pkg::PCI_HEADER_OFF: begin
                rdata_nxt = {16'h0000, pci_header};
            end
            error_log_pkg::PCI_ADDR_LO_OFF: begin
                rdata_nxt = pci_addr_lo;
            end
            error_log_pkg::PCI_ADDR_HI_OFF: begin
                rdata_nxt = pci_addr_hi;
            end
            error_log_pkg::PCI_DATA_LO_OFF: begin
                rdata_nxt = pci_data_lo;
            end
            error_log_pkg::PCI_DATA_HI_OFF: begin
                rdata_nxt = pci_data_hi;
            end
            error_log_pkg::HUB_HEADER_OFF: begin
                if (cfg_dev_in == error_log_pkg::HUB_VIS_DEV) begin
                    rdata_nxt = hub_header;
                end
            end
            error_log_pkg::HUB_ADDR_LO_OFF: begin
                if (cfg_dev_in == error_log_pkg::HUB_VIS_DEV) begin
                    rdata_nxt = hub_addr_lo;
                end
            end
            error_log_pkg::HUB_ADDR_HI_OFF: begin
                if (cfg_dev_in == error_log_pkg::HUB_VIS_DEV) begin
                    rdata_nxt = hub_addr_hi;
                end
            end
            default: begin
                hit_nxt = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clk_in) begin
        if (!reset_n_in) begin
            cfg_rdata_out <= 32'h0000_0000;
            cfg_hit_out <= 1'b0;
        end else if (cfg_rd_in) begin
            cfg_rdata_out <= rdata_nxt;
            cfg_hit_out <= hit_nxt;
        end else begin
            cfg_hit_out <= 1'b0;
        end
    end

    // =========================================================
    // Validity indications, registered from the qualifying flags
    always_ff @(posedge clk_in) begin
        if (!reset_n_in) begin
            pci_log_valid_out <= 1'b0;
            hub_hdr_valid_out <= 1'b0;
            hub_addr_valid_out <= 1'b0;
        end else begin
            pci_log_valid_out <= pci_qual;
            hub_hdr_valid_out <= hub_hdr_qual;
            hub_addr_valid_out <= hub_addr_qual;
        end
    end

endmodule

// ==== bus_error_capture_log_props.sv ====
// Checker for the bus error capture log, watching top module ports only.
// Assumes one core clock and a synchronous active-low reset.
`timescale 1ns/100ps
module bus_error_capture_log_props (
    input wire logic clk_in, // Core clock
    input wire logic reset_n_in, // Sync reset, active low
    input wire logic [11:0] error_status_in, // Flag vector
    input wire logic cfg_rd_in, // Read strobe
    input wire logic [4:0] cfg_dev_in, // Device number
    input wire logic [7:0] cfg_offset_in, // Byte offset
    input wire logic [31:0] cfg_rdata_out, // Read data
    input wire logic cfg_hit_out, // Mapped read seen
    input wire logic pci_log_valid_out, // PCI logs qualified
    input wire logic hub_hdr_valid_out, // Hub header qualified
    input wire logic hub_addr_valid_out // Hub address qualified
);
    // =========================================================
    // Offset decode
    logic mapped;
    logic hub_off;
    assign hub_off = cfg_offset_in inside {8'h80, 8'h84, 8'h88};
    assign mapped = hub_off || (cfg_offset_in inside
        {8'h6C, 8'h70, 8'h74, 8'h78, 8'h7C});

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!reset_n_in);

    // =========================================================
    // Read sequences
    sequence s_rd_mapped;
        cfg_rd_in && mapped;
    endsequence
    sequence s_rd_unmapped;
        cfg_rd_in && !mapped;
    endsequence
    sequence s_rd_hub_other;
        cfg_rd_in && hub_off && cfg_dev_in != error_log_pkg::HUB_VIS_DEV;
    endsequence

    // =========================================================
    // Assertions
    a_pci_valid_mask: assert property ($past(reset_n_in) |->
        pci_log_valid_out == (|($past(error_status_in) & 12'h01F)))
        else $error("pci log valid does not follow its five flags");
    a_hub_hdr_mask: assert property ($past(reset_n_in) |->
        hub_hdr_valid_out == (|($past(error_status_in) & 12'hFE0)))
        else $error("hub header valid does not follow its seven flags");
    a_hub_addr_mask: assert property ($past(reset_n_in) |->
        hub_addr_valid_out == (|($past(error_status_in) & 12'hDE0)))
        else $error("hub address valid does not follow its six flags");
    a_mapped_read_hit: assert property (s_rd_mapped |=> cfg_hit_out)
        else $error("mapped read gave no hit");
    a_unmapped_read_zero: assert property (s_rd_unmapped |=>
        cfg_rdata_out == 32'h0000_0000 && !cfg_hit_out)
        else $error("unmapped read gave data or hit");
    a_hub_dev_gate: assert property (s_rd_hub_other |=>
        cfg_rdata_out == 32'h0000_0000 && cfg_hit_out)
        else $error("hub log visible from wrong device");
    a_hit_needs_read: assert property (cfg_hit_out |->
        $past(cfg_rd_in) && $past(mapped))
        else $error("hit without a mapped read");
    a_rdata_holds: assert property ($past(reset_n_in) &&
        !$past(cfg_rd_in) |-> $stable(cfg_rdata_out))
        else $error("read data changed without a read");
endmodule

bind bus_error_capture_log bus_error_capture_log_props u_props (
    .clk_in(clk_in),
    .reset_n_in(reset_n_in),
    .error_status_in(error_status_in),
    .cfg_rd_in(cfg_rd_in),
    .cfg_dev_in(cfg_dev_in),
    .cfg_offset_in(cfg_offset_in),
    .cfg_rdata_out(cfg_rdata_out),
    .cfg_hit_out(cfg_hit_out),
    .pci_log_valid_out(pci_log_valid_out),
    .hub_hdr_valid_out(hub_hdr_valid_out),
    .hub_addr_valid_out(hub_addr_valid_out)
);

// ==== error_log_pkg.sv ====
// Package for the bus error capture log: offsets, fields, flag positions.
// Assumes a single bridge core clock and a configuration read port.
package error_log_pkg;

    // =========================================================
    // Register offsets (configuration space byte addresses)
    localparam logic [7:0] PCI_HEADER_OFF = 8'h6C;
    localparam logic [7:0] PCI_ADDR_LO_OFF = 8'h70;
    localparam logic [7:0] PCI_ADDR_HI_OFF = 8'h74;
    localparam logic [7:0] PCI_DATA_LO_OFF = 8'h78;
    localparam logic [7:0] PCI_DATA_HI_OFF = 8'h7C;
    localparam logic [7:0] HUB_HEADER_OFF = 8'h80;
    localparam logic [7:0] HUB_ADDR_LO_OFF = 8'h84;
    localparam logic [7:0] HUB_ADDR_HI_OFF = 8'h88;

    // =========================================================
    // Header log field positions
    localparam int CMD_LSB = 8;
    localparam int CMD_W = 4;
    localparam int BE_LSB = 0;
    localparam int BE_W = 8;
    localparam int BE32_W = 4;

    // =========================================================
    // Flag positions in the error status vector (12 flags)
    localparam int FLAG_W = 12;
    localparam int F_PCI_ADDR = 0;
    localparam int F_PCI_DATA = 1;
    localparam int F_PCI_TABORT = 2;
    localparam int F_PCI_MABORT = 3;
    localparam int F_OB_SOFT = 4;
    localparam int F_HUB_ADDR_MB = 5;
    localparam int F_HUB_ADDR_SB = 6;
    localparam int F_HUB_DATA_MB = 7;
    localparam int F_HUB_DATA_SB = 8;
    localparam int F_IB_SOFT = 9;
    localparam int F_HUB_TABORT = 10;
    localparam int F_HUB_MABORT = 11;

    // Flag groups that qualify each log
    localparam logic [11:0] PCI_LOG_MASK = 12'h01F;
    localparam logic [11:0] HUB_HDR_MASK = 12'hFE0;
    localparam logic [11:0] HUB_ADDR_MASK = 12'hDE0;

    // Device number that may see the hub logs
    localparam logic [4:0] HUB_VIS_DEV = 5'h1F;

    // Logs have undefined power-on contents; zero used for sim cleanliness
    localparam logic [31:0] LOG_RESET = 32'h0000_0000;

endpackage

// ==== hub_capture.sv ====
// Hub side capture of packet header and address.
// Assumes the destination address lookup is provided from outside.
`timescale 1ns/100ps
module hub_capture (
    input wire logic clk_in, // Core clock
    input wire logic reset_n_in, // Sync reset, active low
    input wire logic hdr_load_in, // Header capture pulse
    input wire logic addr_load_in, // Address capture pulse
    input wire logic [31:0] hdr_in, // Raw packet header
    input wire logic [63:0] addr_in, // Packet address
    input wire logic read_cpl_in, // Packet is a read completion
    input wire logic [63:0] dest_addr_in, // Address from hub/pipe id
    output logic [31:0] header_out, // Header log
    output logic [31:0] addr_lo_out, // Address low log
    output logic [31:0] addr_hi_out // Address high log
);

    logic [63:0] addr_sel;

    // Completions carry no address, so use the inferred destination
    assign addr_sel = read_cpl_in ? dest_addr_in : addr_in;

    // =========================================================
    // Header log
    always_ff @(posedge clk_in) begin
        if (!reset_n_in) begin
            header_out <= error_log_pkg::LOG_RESET;
        end else if (hdr_load_in) begin
            header_out <= hdr_in;
        end
    end

    // =========================================================
    // Address logs
    always_ff @(posedge clk_in) begin
        if (!reset_n_in) begin
            addr_lo_out <= error_log_pkg::LOG_RESET;
            addr_hi_out <= error_log_pkg::LOG_RESET;
        end else if (addr_load_in) begin
            addr_lo_out <= addr_sel[31:0];
            addr_hi_out <= addr_sel[63:32];
        end
    end

endmodule

// ==== pci_capture.sv ====
// PCI side capture of command, byte enables, address and data.
// Assumes a one-cycle capture pulse from the error detection logic.
`timescale 1ns/100ps
module pci_capture (
    input wire logic clk_in, // Core clock
    input wire logic reset_n_in, // Sync reset, active low
    input wire logic load_in, // Capture pulse
    input wire logic [3:0] cmd_in, // Bus command
    input wire logic [7:0] be_in, // Byte enables
    input wire logic mode32_in, // Cycle ran in 32-bit mode
    input wire logic [63:0] addr_in, // Cycle address
    input wire logic dual_addr_in, // Dual address cycle
    input wire logic addr_perr_in, // Address parity error event
    input wire logic attr_perr_in, // Attribute parity error event
    input wire logic [31:0] attr_in, // Attribute phase value
    input wire logic [63:0] data_in, // Cycle data
    output logic [15:0] header_out, // Header log
    output logic [31:0] addr_lo_out, // Address low log
    output logic [31:0] addr_hi_out, // Address high log
    output logic [31:0] data_lo_out, // Data low log
    output logic [31:0] data_hi_out // Data high log
);

    // =========================================================
    // Header log
    always_ff @(posedge clk_in) begin
        if (!reset_n_in) begin
            header_out <= error_log_pkg::LOG_RESET[15:0];
        end else if (load_in) begin
            header_out <= 16'h0000;
            header_out[error_log_pkg::CMD_LSB +: error_log_pkg::CMD_W]
                <= cmd_in;
            // Upper byte enables are undefined in 32-bit mode; zero them
            header_out[error_log_pkg::BE_LSB +: error_log_pkg::BE_W]
                <= mode32_in ? {4'h0, be_in[error_log_pkg::BE32_W-1:0]}
                             : be_in;
        end
    end

    // =========================================================
    // Address logs
    always_ff @(posedge clk_in) begin
        if (!reset_n_in) begin
            addr_lo_out <= error_log_pkg::LOG_RESET;
            addr_hi_out <= error_log_pkg::LOG_RESET;
        end else if (load_in) begin
            addr_lo_out <= addr_in[31:0];
            if (addr_perr_in && !dual_addr_in) begin
                addr_hi_out <= 32'h0000_0000;
            end else begin
                addr_hi_out <= addr_in[63:32];
            end
        end
    end

    // =========================================================
    // Data logs
    always_ff @(posedge clk_in) begin
        if (!reset_n_in) begin
            data_lo_out <= error_log_pkg::LOG_RESET;
            data_hi_out <= error_log_pkg::LOG_RESET;
        end else if (load_in) begin
            // Address phase errors leave the low word meaningless
            if (attr_perr_in) begin
                data_lo_out <= attr_in;
            end else if (addr_perr_in) begin
                data_lo_out <= 32'h0000_0000;
            end else begin
                data_lo_out <= data_in[31:0];
            end
            data_hi_out <= data_in[63:32];
        end
    end

endmodule

// ==== tb_bus_error_capture_log.sv ====
// Self-checking testbench for the bus error capture log.
// Assumes inputs driven at the falling edge and one-cycle read latency.
`timescale 1ns/100ps
module tb_bus_error_capture_log;
    logic clk_in, reset_n_in, pci_error_in, pci_mode32_in;
    logic pci_dual_addr_in, pci_addr_perr_in, pci_attr_perr_in;
    logic hub_error_in, hub_ib_soft_in, hub_read_cpl_in, cfg_rd_in;
    logic cfg_hit_out, pci_log_valid_out, hub_hdr_valid_out;
    logic hub_addr_valid_out;
    logic [11:0] error_status_in;
    logic [3:0] pci_cmd_in;
    logic [7:0] pci_be_in, cfg_offset_in;
    logic [4:0] cfg_dev_in;
    logic [31:0] pci_attr_in, hub_header_in, cfg_rdata_out;
    logic [63:0] pci_addr_in, pci_data_in, hub_addr_in, hub_dest_addr_in;
    int err_count = 0;
    int checks = 0;

    bus_error_capture_log dut (.clk_in(clk_in), .reset_n_in(reset_n_in),
        .error_status_in(error_status_in), .pci_error_in(pci_error_in),
        .pci_cmd_in(pci_cmd_in), .pci_be_in(pci_be_in),
        .pci_mode32_in(pci_mode32_in), .pci_addr_in(pci_addr_in),
        .pci_dual_addr_in(pci_dual_addr_in),
        .pci_addr_perr_in(pci_addr_perr_in),
        .pci_attr_perr_in(pci_attr_perr_in), .pci_attr_in(pci_attr_in),
        .pci_data_in(pci_data_in), .hub_error_in(hub_error_in),
        .hub_ib_soft_in(hub_ib_soft_in), .hub_header_in(hub_header_in),
        .hub_addr_in(hub_addr_in), .hub_read_cpl_in(hub_read_cpl_in),
        .hub_dest_addr_in(hub_dest_addr_in), .cfg_rd_in(cfg_rd_in),
        .cfg_dev_in(cfg_dev_in), .cfg_offset_in(cfg_offset_in),
        .cfg_rdata_out(cfg_rdata_out), .cfg_hit_out(cfg_hit_out),
        .pci_log_valid_out(pci_log_valid_out),
        .hub_hdr_valid_out(hub_hdr_valid_out),
        .hub_addr_valid_out(hub_addr_valid_out));

    initial begin
        clk_in = 1'b0;
        forever #4 clk_in = ~clk_in;
    end

    // =========================================================
    // Shared tasks
    task tally_and_finish;
        $display("Comparisons %0d, mismatches %0d", checks, err_count);
        if (err_count == 0 && checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task chk(input logic [31:0] g, input logic [31:0] e);
        checks++;
        if (g !== e) begin
            err_count++;
            $display("Error at %0t: got %h expected %h", $time, g, e);
        end
    endtask

    task rd(input logic [4:0] dv, input logic [7:0] off,
            input logic [31:0] e, input logic eh);
        @(negedge clk_in);
        cfg_rd_in = 1'b1;
        cfg_dev_in = dv;
        cfg_offset_in = off;
        @(negedge clk_in);
        cfg_rd_in = 1'b0;
        chk(cfg_rdata_out, e);
        chk({31'h0, cfg_hit_out}, {31'h0, eh});
    endtask

    task pci_evt(input logic [3:0] c, input logic [7:0] b, input logic m,
                 input logic [63:0] a, input logic du, ap, tp,
                 input logic [31:0] at, input logic [63:0] d,
                 input logic [11:0] fl);
        @(negedge clk_in);
        {pci_error_in, pci_cmd_in, pci_be_in, pci_mode32_in} = {1'b1, c, b, m};
        {pci_addr_in, pci_dual_addr_in, pci_addr_perr_in} = {a, du, ap};
        {pci_attr_perr_in, pci_attr_in, pci_data_in} = {tp, at, d};
        error_status_in = fl;
        @(negedge clk_in);
        pci_error_in = 1'b0;
    endtask

    task hub_evt(input logic ib, input logic [31:0] h, input logic [63:0] a,
                 input logic cp, input logic [63:0] ds, input logic [11:0] fl);
        @(negedge clk_in);
        {hub_error_in, hub_ib_soft_in, hub_header_in} = {1'b1, ib, h};
        {hub_addr_in, hub_read_cpl_in, hub_dest_addr_in} = {a, cp, ds};
        error_status_in = fl;
        @(negedge clk_in);
        hub_error_in = 1'b0;
    endtask

    task clr;
        @(negedge clk_in);
        error_status_in = 12'h000;
        repeat (3) @(negedge clk_in);
    endtask

    // =========================================================
    // Scenarios
    task t_reset_map;
        static logic [7:0] offs [8] = '{8'h6C, 8'h70, 8'h74, 8'h78,
                                        8'h7C, 8'h80, 8'h84, 8'h88};
        foreach (offs[i]) rd(5'h1F, offs[i], 32'h0, 1'b1);
        rd(5'h1F, 8'h60, 32'h0, 1'b0);
        rd(5'h1F, 8'h8C, 32'h0, 1'b0);
        $display("reset and map test done");
    endtask

    task t_pci_basic;
        pci_evt(4'h7, 8'hA5, 0, 64'h1234_5678_9ABC_DEF0, 1, 0, 0,
                32'h1111_2222, 64'hCAFE_F00D_0BAD_BEEF, 12'h002);
        rd(5'h1D, 8'h6C, 32'h0000_07A5, 1'b1);
        rd(5'h1F, 8'h70, 32'h9ABC_DEF0, 1'b1);
        rd(5'h1F, 8'h74, 32'h1234_5678, 1'b1);
        rd(5'h1F, 8'h78, 32'h0BAD_BEEF, 1'b1);
        rd(5'h1D, 8'h7C, 32'hCAFE_F00D, 1'b1);
        chk({31'h0, pci_log_valid_out}, 32'h1);
        pci_evt(4'hF, 8'hFF, 0, 64'h0, 1, 0, 0, 32'h0, 64'h0, 12'h002);
        rd(5'h1F, 8'h70, 32'h9ABC_DEF0, 1'b1);
        clr();
        chk({31'h0, pci_log_valid_out}, 32'h0);
        $display("pci capture test done");
    endtask

    task t_pci_perr;
        pci_evt(4'h3, 8'hF3, 1, 64'hAAAA_5555_0000_0104, 0, 1, 0,
                32'h3333_4444, 64'h7777_8888_9999_AAAA, 12'h001);
        rd(5'h1F, 8'h6C, 32'h0000_0303, 1'b1);
        rd(5'h1F, 8'h70, 32'h0000_0104, 1'b1);
        rd(5'h1F, 8'h74, 32'h0000_0000, 1'b1);
        rd(5'h1F, 8'h78, 32'h0000_0000, 1'b1);
        clr();
        pci_evt(4'hE, 8'h0F, 0, 64'h0000_0001_8000_0000, 1, 0, 1,
                32'h5A5A_C3C3, 64'h0102_0304_0506_0708, 12'h010);
        rd(5'h1F, 8'h78, 32'h5A5A_C3C3, 1'b1);
        rd(5'h1F, 8'h74, 32'h0000_0001, 1'b1);
        clr();
        $display("pci parity test done");
    endtask

    task t_hub;
        hub_evt(0, 32'hF00F_0FF0, 64'h0000_00AB_1234_5673, 0,
                64'h1, 12'h020);
        rd(5'h1F, 8'h80, 32'hF00F_0FF0, 1'b1);
        rd(5'h1F, 8'h84, 32'h1234_5673, 1'b1);
        rd(5'h1F, 8'h88, 32'h0000_00AB, 1'b1);
        rd(5'h1E, 8'h84, 32'h0000_0000, 1'b1);
        hub_evt(0, 32'h0, 64'h0, 0, 64'h0, 12'h020);
        rd(5'h1F, 8'h80, 32'hF00F_0FF0, 1'b1);
        clr();
        hub_evt(0, 32'h0C00_0001, 64'hFFFF_FFFF_FFFF_FFFF, 1,
                64'h0000_0042_00C0_FFEC, 12'h400);
        rd(5'h1F, 8'h84, 32'h00C0_FFEC, 1'b1);
        rd(5'h1F, 8'h88, 32'h0000_0042, 1'b1);
        clr();
        hub_evt(1, 32'h0000_8001, 64'h5, 0, 64'h6, 12'h200);
        rd(5'h1F, 8'h80, 32'h0000_8001, 1'b1);
        chk({31'h0, hub_hdr_valid_out}, 32'h1);
        chk({31'h0, hub_addr_valid_out}, 32'h0);
        rd(5'h1F, 8'h84, 32'h00C0_FFEC, 1'b1);
        clr();
        $display("hub capture test done");
    endtask

    initial begin
        {reset_n_in, pci_error_in, pci_mode32_in, pci_dual_addr_in} = 4'h0;
        {pci_addr_perr_in, pci_attr_perr_in, hub_error_in} = 3'h0;
        {hub_ib_soft_in, hub_read_cpl_in, cfg_rd_in} = 3'h0;
        {error_status_in, pci_cmd_in, pci_be_in, cfg_dev_in} = 29'h0;
        {cfg_offset_in, pci_attr_in, hub_header_in} = 72'h0;
        {pci_addr_in, pci_data_in, hub_addr_in, hub_dest_addr_in} = 256'h0;
        repeat (10) @(negedge clk_in);
        reset_n_in = 1'b1;
        t_reset_map();
        t_pci_basic();
        t_pci_perr();
        t_hub();
        tally_and_finish();
    end

    initial begin
        #200000;
        err_count++;
        tally_and_finish();
    end
endmodule
